// ==== include/ramp_ctrl_pkg.sv ====
// Purpose: shared constants for the reference ramp and mode select block
// Assumes: 25 MHz system clock, register map reached over the two-wire port
// Notes:   register pointer and data are one byte wide
package ramp_ctrl_pkg;
  // register byte addresses
  localparam logic [7:0] REG_ENABLE = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h01;
  localparam logic [7:0] REG_MISC   = 8'h03;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h09;
  localparam logic [7:0] REG_REF    = 8'h0a;

  // field positions
  localparam int EN_BIT     = 0;
  localparam int HALF_BIT   = 4;
  localparam int GM_LSB     = 0;
  localparam int SLEW_LSB   = 4;
  localparam int ST_RAMP    = 0;
  localparam int ST_BOOST   = 1;
  localparam int ST_ON      = 2;
  localparam int ST_REF_LSB = 3;

  // reset values and limits
  localparam logic       EN_RST     = 1'b1;
  localparam logic [7:0] TARGET_RST = 8'h32;
  localparam logic [7:0] TARGET_MIN = 8'h0a;
  localparam logic       HALF_RST   = 1'b0;
  localparam logic [2:0] GM_RST     = 3'h5;
  localparam logic [1:0] SLEW_RST   = 2'h0;

  // ramp timing: one 9-bit code step is 5 mV at the feedback node
  localparam int CLK_MHZ     = 25;
  localparam int STEP_UV     = 5000;
  localparam int SLEW0_UV_US = 600;

  // modulation triangle, top and crossing point
  localparam logic [7:0] RAMP_TOP = 8'h14;
  localparam logic [7:0] RAMP_MID = 8'h0a;
  localparam logic [7:0] ONE8     = 8'h01;
  localparam logic [8:0] ONE9     = 9'h001;
  localparam logic [11:0] ONE12   = 12'h001;

  // clock cycles per reference step for a slew select code
  function automatic logic [11:0] slew_cycles(input logic [1:0] sel);
    int c;
    c = (STEP_UV * CLK_MHZ) / (SLEW0_UV_US << sel);
    slew_cycles = 12'(c);
  endfunction
endpackage

// ==== src/twowire_slave.sv ====
// Purpose: two-wire register port slave with auto-incrementing pointer
// Assumes: scl_i and sda_i already synchronous to clock_i
// Notes:   first written byte sets the pointer, later bytes write data
module twowire_slave
  import ramp_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary value
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            wr_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  input  wire logic [7:0] rdata_i
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK} tw_state_t;

  tw_state_t  st_q, st_d;
  logic       scl_q, sda_q;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic       done_q, done_d, rw_q, rw_d, first_q, first_d, nack_q, nack_d, wr_q, wr_d;
  logic       rise, fall, start, stop;

  assign rise     = scl_i & ~scl_q;
  assign fall     = ~scl_i & scl_q;
  assign start    = scl_i & scl_q & sda_q & ~sda_i;
  assign stop     = scl_i & scl_q & ~sda_q & sda_i;
  assign sda_o    = 1'b0;
  assign sda_oe_o = (st_q == S_AACK) | (st_q == S_WACK) | ((st_q == S_RD) & ~sh_q[7]);
  assign wr_o     = wr_q;
  assign addr_o   = ptr_q;
  assign wdata_o  = sh_q;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    done_d  = done_q;
    rw_d    = rw_q;
    first_d = first_q;
    nack_d  = nack_q;
    wr_d    = 1'b0;
    if (start) begin
      st_d   = S_ADDR;
      cnt_d  = 3'h0;
      done_d = 1'b0;
    end else if (stop) begin
      st_d = S_IDLE;
    end else begin
      unique case (st_q)
        S_IDLE: ;
        S_ADDR, S_WR: begin
          if (rise) begin
            sh_d   = {sh_q[6:0], sda_i};
            done_d = (cnt_q == 3'h7);
            cnt_d  = cnt_q + 3'h1;
          end else if (fall && done_q) begin
            done_d = 1'b0;
            if (st_q == S_ADDR) begin
              rw_d    = sh_q[0];
              first_d = 1'b1;
              st_d    = (sh_q[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
            end else begin
              st_d    = S_WACK;
              if (first_q) begin
                ptr_d = sh_q;
              end else begin
                wr_d = 1'b1;
              end
            end
          end
        end
        S_AACK, S_WACK: begin
          if (fall) begin
            cnt_d = 3'h0;
            // the pointer byte itself does not advance the pointer
            if (st_q == S_WACK) begin
              if (first_q) begin
                first_d = 1'b0;
              end else begin
                ptr_d = ptr_q + ONE8;
              end
            end
            if (st_q == S_AACK && rw_q) begin
              st_d = S_RD;
              sh_d = rdata_i;
            end else begin
              st_d = S_WR;
            end
          end
        end
        S_RD: begin
          if (fall) begin
            sh_d  = {sh_q[6:0], 1'b1};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              st_d  = S_RACK;
              ptr_d = ptr_q + ONE8;
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            nack_d = sda_i;
          end else if (fall) begin
            if (nack_q) begin
              st_d = S_IDLE;
            end else begin
              st_d  = S_RD;
              sh_d  = rdata_i;
              cnt_d = 3'h0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q    <= S_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      cnt_q   <= 3'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      done_q  <= 1'b0;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
      wr_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      scl_q   <= scl_i;
      sda_q   <= sda_i;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      done_q  <= done_d;
      rw_q    <= rw_d;
      first_q <= first_d;
      nack_q  <= nack_d;
      wr_q    <= wr_d;
    end
  end
endmodule

// ==== src/reference_ramp_and_mode_select.sv ====
// Purpose: reference target, slew-limited reference ramp, gm select and buck/boost selection
// Assumes: all inputs synchronous to clock_i; comp_code_i is the digitised error-amp output
// Notes:   reference code is 9 bits in 5 mV units, switch outputs are registered
module reference_ramp_and_mode_select
  import ramp_ctrl_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       enable_pin_i,
  input  wire logic       pos_ilim_i,
  input  wire logic       neg_ilim_i,
  input  wire logic [7:0] comp_code_i,
  output logic [8:0]      reference_code_o,
  output logic [2:0]      gm_select_o,
  output logic [7:0]      ramp_a_o,
  output logic [7:0]      ramp_b_o,
  output logic            boost_mode_o,
  output logic            input_high_switch_o,
  output logic            input_low_switch_o,
  output logic            output_low_switch_o,
  output logic            output_high_switch_o
);
  logic       wr;
  logic [7:0] waddr, wdata, rdata;

  twowire_slave u_port (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe_o (sda_oe_o),
    .wr_o     (wr),
    .addr_o   (waddr),
    .wdata_o  (wdata),
    .rdata_i  (rdata)
  );

  // register file
  logic       en_q, en_d, half_q, half_d;
  logic [7:0] target_q, target_d;
  logic [2:0] gm_q, gm_d;
  logic [1:0] slew_q, slew_d;

  always_comb begin
    en_d     = en_q;
    target_d = target_q;
    half_d   = half_q;
    gm_d     = gm_q;
    slew_d   = slew_q;
    if (wr) begin
      unique case (waddr)
        REG_ENABLE: en_d = wdata[EN_BIT];
        REG_TARGET: begin
          if (wdata >= TARGET_MIN) begin
            target_d = wdata;
          end
        end
        REG_MISC:   half_d = wdata[HALF_BIT];
        REG_CTRL: begin
          gm_d   = wdata[GM_LSB +: 3];
          slew_d = wdata[SLEW_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      en_q     <= EN_RST;
      target_q <= TARGET_RST;
      half_q   <= HALF_RST;
      gm_q     <= GM_RST;
      slew_q   <= SLEW_RST;
    end else begin
      en_q     <= en_d;
      target_q <= target_d;
      half_q   <= half_d;
      gm_q     <= gm_d;
      slew_q   <= slew_d;
    end
  end

  // reference ramp
  logic       on;
  logic [8:0] ref_q, ref_d, goal;
  logic [11:0] div_q, div_d;
  logic       tick;

  assign on   = enable_pin_i & en_q;
  assign goal = {target_q, half_q};
  assign tick = (div_q == 12'h000);

  always_comb begin
    div_d = div_q - ONE12;
    if (!on || tick) begin
      div_d = slew_cycles(slew_q) - ONE12;
    end
    ref_d = ref_q;
    if (!on) begin
      ref_d = 9'h000;  // a disable drops the reference, next enable restarts from zero
    end else if (tick) begin
      if (ref_q < goal && !pos_ilim_i) begin
        ref_d = ref_q + ONE9;
      end else if (ref_q > goal && !neg_ilim_i) begin
        ref_d = ref_q - ONE9;
      end
    end
  end

  // single-code steps land on the target and stay there
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ref_q <= 9'h000;
      div_q <= 12'h000;
    end else begin
      ref_q <= ref_d;
      div_q <= div_d;
    end
  end

  // modulation triangles and mode selection
  logic [7:0] ra_q, ra_d, rb;
  logic       up_q, up_d, boost_q, boost_d;
  logic       ih_q, ih_d, il_q, il_d, ol_q, ol_d, oh_q, oh_d;

  assign rb = RAMP_TOP - ra_q;

  always_comb begin
    up_d = up_q;
    if (up_q) begin
      ra_d = ra_q + ONE8;
      if (ra_q == RAMP_TOP - ONE8) begin
        up_d = 1'b0;
      end
    end else begin
      ra_d = ra_q - ONE8;
      if (ra_q == ONE8) begin
        up_d = 1'b1;
      end
    end
    boost_d = boost_q;
    if (ra_q == RAMP_MID) begin
      boost_d = (comp_code_i > RAMP_MID);
    end
    ih_d = 1'b0;
    il_d = 1'b0;
    ol_d = 1'b0;
    oh_d = 1'b0;
    if (on) begin
      if (boost_q) begin
        ih_d = 1'b1;
        ol_d = (comp_code_i > rb);
        oh_d = ~(comp_code_i > rb);
      end else begin
        oh_d = 1'b1;
        ih_d = (comp_code_i > ra_q);
        il_d = ~(comp_code_i > ra_q);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ra_q    <= 8'h00;
      up_q    <= 1'b1;
      boost_q <= 1'b0;
      ih_q    <= 1'b0;
      il_q    <= 1'b0;
      ol_q    <= 1'b0;
      oh_q    <= 1'b0;
    end else begin
      ra_q    <= ra_d;
      up_q    <= up_d;
      boost_q <= boost_d;
      ih_q    <= ih_d;
      il_q    <= il_d;
      ol_q    <= ol_d;
      oh_q    <= oh_d;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    unique case (waddr)
      REG_ENABLE: rdata[EN_BIT] = en_q;
      REG_TARGET: rdata = target_q;
      REG_MISC:   rdata[HALF_BIT] = half_q;
      REG_CTRL: begin
        rdata[GM_LSB +: 3]   = gm_q;
        rdata[SLEW_LSB +: 2] = slew_q;
      end
      REG_STATUS: begin
        rdata[ST_RAMP]    = (ref_q != goal);
        rdata[ST_BOOST]   = boost_q;
        rdata[ST_ON]      = on;
        rdata[ST_REF_LSB] = ref_q[0];
      end
      REG_REF:    rdata = ref_q[8:1];
      default: ;
    endcase
  end

  assign reference_code_o     = ref_q;
  assign gm_select_o          = gm_q;
  assign ramp_a_o             = ra_q;
  assign ramp_b_o             = rb;
  assign boost_mode_o         = boost_q;
  assign input_high_switch_o  = ih_q;
  assign input_low_switch_o   = il_q;
  assign output_low_switch_o  = ol_q;
  assign output_high_switch_o = oh_q;
endmodule

// ==== bench/ramp_mode_checker.sv ====
// Purpose: port-level assertions for the ramp and mode select block
// Assumes: enable register stays at its reset value
// Notes:   bound to every instance of the block
module ramp_mode_checker
  import ramp_ctrl_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       enable_pin_i,
  input wire logic       pos_ilim_i,
  input wire logic       neg_ilim_i,
  input wire logic [7:0] comp_code_i,
  input wire logic [8:0] reference_code_o,
  input wire logic [2:0] gm_select_o,
  input wire logic [7:0] ramp_a_o,
  input wire logic [7:0] ramp_b_o,
  input wire logic       boost_mode_o,
  input wire logic       input_high_switch_o,
  input wire logic       input_low_switch_o,
  input wire logic       output_low_switch_o,
  input wire logic       output_high_switch_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_ramp_b_mirror: assert property (ramp_b_o == RAMP_TOP - ramp_a_o)
    else $error("ramp b is not the mirror of ramp a");
  a_ref_single_step: assert property (enable_pin_i && $past(enable_pin_i) |->
    (reference_code_o - $past(reference_code_o)) inside {9'h000, 9'h001, 9'h1ff})
    else $error("reference moved more than one code");
  a_step_spacing: assert property ($changed(reference_code_o) && enable_pin_i |=>
    $stable(reference_code_o) [*8])
    else $error("reference steps too close together");
  a_pos_ilim_freeze: assert property (pos_ilim_i |=> reference_code_o <= $past(reference_code_o))
    else $error("reference rose under positive limit");
  a_neg_ilim_freeze: assert property (neg_ilim_i && enable_pin_i |=>
    reference_code_o >= $past(reference_code_o))
    else $error("reference fell under negative limit");
  a_mode_at_mid: assert property (enable_pin_i && ramp_a_o == RAMP_MID |=>
    boost_mode_o == ($past(comp_code_i) > RAMP_MID))
    else $error("mode not decided at ramp midpoint");
  a_boost_pattern: assert property (!$past(rst_i) && $past(boost_mode_o) && $past(enable_pin_i)
    && enable_pin_i |-> input_high_switch_o && !input_low_switch_o && output_low_switch_o != output_high_switch_o)
    else $error("boost switch pattern wrong");
  a_buck_pattern: assert property (!$past(rst_i) && !$past(boost_mode_o) && $past(enable_pin_i)
    && enable_pin_i |-> output_high_switch_o && !output_low_switch_o && input_high_switch_o != input_low_switch_o)
    else $error("buck switch pattern wrong");
  a_reset_state: assert property ($past(rst_i) |-> gm_select_o == GM_RST
    && reference_code_o == 9'h000 && !boost_mode_o)
    else $error("outputs wrong after reset");
endmodule

bind reference_ramp_and_mode_select ramp_mode_checker chk (
  .clock_i(clock_i), .rst_i(rst_i), .enable_pin_i(enable_pin_i), .pos_ilim_i(pos_ilim_i),
  .neg_ilim_i(neg_ilim_i), .comp_code_i(comp_code_i), .reference_code_o(reference_code_o),
  .gm_select_o(gm_select_o), .ramp_a_o(ramp_a_o), .ramp_b_o(ramp_b_o), .boost_mode_o(boost_mode_o),
  .input_high_switch_o(input_high_switch_o), .input_low_switch_o(input_low_switch_o),
  .output_low_switch_o(output_low_switch_o), .output_high_switch_o(output_high_switch_o)
);

// ==== bench/twowire_host_model.sv ====
// Purpose: two-wire host that writes and reads the block's registers
// Assumes: open-drain data line with a pull-up in the bench
// Notes:   every line level is held four clocks
module twowire_host_model #(
  parameter logic [6:0] DEV = 7'h2a
) (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic drive(input logic c, input logic d);
    @(posedge clock_i);
    scl_o <= c;
    sda_pull_o <= !d;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic bit_io(input logic b, output logic r);
    drive(1'b0, b);
    drive(1'b1, b);
    r = sda_i;
  endtask
  task automatic start;
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
  endtask
  task automatic stop;
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask
  // last is the ninth bit sent: 1 releases the line for the slave's ack
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(last, ack);
    ack = !ack;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    start;
    byte_io({dev, 1'b0}, 1'b1, r, k0);
    byte_io(a, 1'b1, r, k1);
    byte_io(d, 1'b1, r, k2);
    stop;
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic       k;
    start;
    byte_io({DEV, 1'b0}, 1'b1, r, k);
    byte_io(a, 1'b1, r, k);
    start;
    byte_io({DEV, 1'b1}, 1'b1, r, k);
    byte_io(8'hff, 1'b1, d, k);
    stop;
  endtask
endmodule

// ==== bench/reference_ramp_and_mode_select_tb.sv ====
// Purpose: self-checking bench for the reference ramp and mode select block
// Assumes: device address 7'h2a, enable register left set
// Notes:   registers are reached only through the two-wire host model
module reference_ramp_and_mode_select_tb
  import ramp_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i, rst_i, enable_pin_i, pos_ilim_i, neg_ilim_i;
  logic [7:0] comp_code_i, ramp_a_o, ramp_b_o;
  logic       scl, host_pull, sda_o, sda_oe_o, boost_mode_o, ih, il, ol, oh;
  logic [8:0] reference_code_o;
  logic [2:0] gm_select_o;
  wire  logic sda_line;
  int         failures, checked, cycles;
  logic [8:0] gaps [4] = '{9'h0d0, 9'h068, 9'h034, 9'h01a};

  assign sda_line = !(host_pull || sda_oe_o);
  always #20 clock_i = ~clock_i;

  reference_ramp_and_mode_select uut (
    .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .enable_pin_i(enable_pin_i), .pos_ilim_i(pos_ilim_i), .neg_ilim_i(neg_ilim_i), .comp_code_i(comp_code_i),
    .reference_code_o(reference_code_o), .gm_select_o(gm_select_o), .ramp_a_o(ramp_a_o), .ramp_b_o(ramp_b_o),
    .boost_mode_o(boost_mode_o), .input_high_switch_o(ih), .input_low_switch_o(il),
    .output_low_switch_o(ol), .output_high_switch_o(oh)
  );
  twowire_host_model host (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(host_pull));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(7'h2a, a, d, ok);
    check("write ack", {8'h00, ok}, 9'h001);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check("read data", {1'b0, d}, {1'b0, exp});
  endtask
  // cycles between two consecutive reference steps
  task automatic gap(output int n);
    logic [8:0] r;
    for (int k = 0; k < 2; k++) begin
      r = reference_code_o;
      n = 0;
      while (reference_code_o === r && n < 5000) begin
        cyc(1);
        n++;
      end
    end
  endtask
  task automatic settle(input logic [8:0] v);
    int n;
    n = 0;
    while (reference_code_o !== v && n < 30000) begin
      cyc(1);
      n++;
    end
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop;
    end
  end

  initial begin
    int         n;
    logic       ok;
    logic [8:0] r;
    clock_i = 1'b0;
    rst_i = 1'b1;
    enable_pin_i = 1'b1;
    pos_ilim_i = 1'b0;
    neg_ilim_i = 1'b0;
    comp_code_i = 8'h00;
    failures = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    cyc(1);
    check("gm reset", {6'h00, gm_select_o}, {6'h00, GM_RST});
    gap(n);
    check("startup gap", 9'(n), gaps[0]);
    host.write_reg(7'h2b, REG_TARGET, 8'h40, ok);
    check("foreign ack", {8'h00, ok}, 9'h000);
    rd(REG_TARGET, TARGET_RST);
    rd(REG_MISC, 8'h00);
    rd(REG_CTRL, 8'h05);
    rd(8'h20, 8'h00);
    rd(REG_ENABLE, 8'h01);
    $display("done reset");
    wr(REG_TARGET, 8'hff);
    for (int i = 0; i < 8; i++) begin
      wr(REG_CTRL, {2'b00, 2'(i % 4), 1'b0, 3'(i)});
      check("gm select", {6'h00, gm_select_o}, {6'h00, 3'(i)});
      gap(n);
      check("step gap", 9'(n), gaps[i % 4]);
    end
    $display("done slew");
    // deliberately writes a reserved code, which a real host avoids
    wr(REG_TARGET, 8'h09);
    rd(REG_TARGET, 8'hff);
    wr(REG_TARGET, TARGET_MIN);
    rd(REG_TARGET, TARGET_MIN);
    settle(9'h014);
    cyc(100);
    check("fall stop", reference_code_o, 9'h014);
    rd(REG_REF, 8'h0a);
    rd(REG_STATUS, 8'h04);
    wr(REG_MISC, 8'h10);
    settle(9'h015);
    cyc(60);
    check("half step", reference_code_o, 9'h015);
    rd(REG_STATUS, 8'h0c);
    $display("done target");
    wr(REG_TARGET, 8'h40);
    @(posedge clock_i) pos_ilim_i <= 1'b1;
    cyc(2);
    r = reference_code_o;
    cyc(200);
    check("rise held", reference_code_o, r);
    @(posedge clock_i) pos_ilim_i <= 1'b0;
    cyc(60);
    check("rise resumed", {8'h00, reference_code_o > r}, 9'h001);
    wr(REG_TARGET, TARGET_MIN);
    @(posedge clock_i) neg_ilim_i <= 1'b1;
    cyc(2);
    r = reference_code_o;
    cyc(200);
    check("fall held", reference_code_o, r);
    @(posedge clock_i) neg_ilim_i <= 1'b0;
    cyc(60);
    check("fall resumed", {8'h00, reference_code_o < r}, 9'h001);
    $display("done limits");
    @(posedge clock_i) comp_code_i <= RAMP_TOP;
    cyc(90);
    check("boost", {6'h00, boost_mode_o, ih, il}, 9'h006);
    @(posedge clock_i) comp_code_i <= RAMP_MID;
    cyc(90);
    check("buck", {6'h00, boost_mode_o, oh, ol}, 9'h002);
    settle(9'h015);
    @(posedge clock_i) enable_pin_i <= 1'b0;
    cyc(3);
    check("off", {4'h0, reference_code_o == 9'h000, ih, il, ol, oh}, 9'h010);
    @(posedge clock_i) enable_pin_i <= 1'b1;
    gap(n);
    check("restart gap", 9'(n), gaps[3]);
    $display("done modes");
    report_and_stop;
  end
endmodule
